// ### qt_pkg.sv
// Shared constants and types for the four counter/timers.
// Assumes one system clock; all pins arrive asynchronously.
`default_nettype none

package qt_pkg;

  // ----------------------------------------------------------------
  // Divider counts
  // ----------------------------------------------------------------
  localparam logic [5:0] QT_DIV12   = 6'h0C;  // System clock / 12
  localparam logic [5:0] QT_DIV4    = 6'h04;  // System clock / 4
  localparam logic [5:0] QT_DIV48   = 6'h30;  // System clock / 48
  localparam logic [2:0] QT_OSC8_LAST = 3'h7; // Last count of a /8 stage

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] QT_CNT_RST  = 16'h0000;
  localparam logic [5:0]  QT_DIV_RST  = 6'h00;
  localparam logic [2:0]  QT_OSC_RST  = 3'h0;
  localparam logic [5:0]  QT_FLAG_RST = 6'h00;
  localparam logic [7:0]  QT_PIN_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Pin vector positions and flag positions
  // ----------------------------------------------------------------
  localparam int QT_PIN_CNT0  = 0;
  localparam int QT_PIN_GATE  = 2;
  localparam int QT_PIN_EXT   = 4;
  localparam int QT_PIN_RTC   = 5;
  localparam int QT_PIN_CMP0  = 6;
  localparam int QT_F_TMR0 = 0;
  localparam int QT_F_TMR1 = 1;
  localparam int QT_F_T2L  = 2;
  localparam int QT_F_T2H  = 3;

  // ----------------------------------------------------------------
  // Modes and configuration carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {QT_M_13BIT, QT_M_16BIT, QT_M_RELOAD8, QT_M_SPLIT} qt_mode_t;
  typedef enum logic [1:0] {QT_PS_DIV12, QT_PS_DIV4, QT_PS_DIV48, QT_PS_EXT8} qt_prescale_t;

  typedef struct packed {
    logic     run_bit;
    logic     gate_enable;
    logic     count_mode;
    logic     clk_sys;
    qt_mode_t mode;
  } qt_t01_cfg_t;

  typedef struct packed {
    logic run_bit;
    logic split;
    logic capture;
    logic low_sys;
    logic high_sys;
    logic alt_clk;
    logic alt_cmp;
  } qt_t23_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  timer;
    logic        reload;
    logic [15:0] data;
  } qt_load_t;

endpackage : qt_pkg

`default_nettype wire

// ### qt_timers.sv
// Four counter/timers: timers 0/1 (13/16/8-reload/split) and 2/3 (16 or split reload, capture).
// Assumes pins asynchronous to clk; configuration and loads come from clk-domain logic.
//
// Notes on behaviour
// - There are four counter/timers, two of them classic 16-bit timers.
// - Timers 2 and 3 run as one 16-bit or two 8-bit auto-reload timers.
// - Timers 0/1 offer 13-bit, 16-bit and 8-bit reload modes; split mode is timer 0 only.
// - Timers 2 and 3 can capture their count on edges of an alternate clock.
// - Timers 0/1 pick the system clock or the shared prescaled clock.
// - Timers 2 and 3 can run on the system clock or the system clock over 12.
// - Timer 2 can also use the RTC oscillator over 8 or comparator 0.
// - Timer 3 can also use the external oscillator over 8 or comparator 1.
// - In counter mode a count pin falling edge increments the timer once.
// - The prescale field gives /12, /4, /48 or external clock /8.
// - A timer counts only while run is set and gating is off or the gate pin is high; timer 0's split high byte runs on timer 1's run bit alone.
// - In 13-bit mode a wrap from 0x1FFF to zero sets the overflow flag.
// - In 8-bit reload mode a low byte overflow sets the flag and reloads from the high byte.
`default_nettype none

module qt_timers
  import qt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         count_input_pin_0,
  input  wire logic         count_input_pin_1,
  input  wire logic         timer0_gate_input,
  input  wire logic         timer1_gate_input,
  input  wire logic         ext_osc_clk,
  input  wire logic         rtc_osc_clk,
  input  wire logic         comparator0_out,
  input  wire logic         comparator1_out,
  input  wire qt_prescale_t prescale_select_field,
  input  wire qt_t01_cfg_t  t01_cfg [2],
  input  wire qt_t23_cfg_t  t23_cfg [2],
  input  wire qt_load_t     load,
  input  wire logic [5:0]   flag_clear,
  output logic [15:0]       t01_count [2],
  output logic [15:0]       t23_count [2],
  output logic [15:0]       t23_reload [2],
  output logic [5:0]        overflow_flags
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_sync_b;
  logic [7:0] pin_raw, pin_s1, pin_s2, pin_s3;
  logic [7:0] pin_fall, pin_rise;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rst_pipe <= 2'h0;
    else        rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync_b = rst_pipe[1];

  assign pin_raw = {comparator1_out, comparator0_out, rtc_osc_clk, ext_osc_clk,
                    timer1_gate_input, timer0_gate_input, count_input_pin_1, count_input_pin_0};

  // Two flops per pin, third stage only for edge detection
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_s1 <= QT_PIN_RST;
      pin_s2 <= QT_PIN_RST;
      pin_s3 <= QT_PIN_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  assign pin_fall = pin_s3 & ~pin_s2;
  assign pin_rise = ~pin_s3 & pin_s2;

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [5:0] pre_cnt, next_pre_cnt, d12_cnt, next_d12_cnt, pre_lim;
  logic [2:0] ext8, next_ext8, rtc8, next_rtc8;
  logic       pre_tick, d12_tick, ext8_tick, rtc8_tick;
  logic [1:0] osc8_tick;

  // Prescaler, system /12 and the two oscillator /8 stages
  always_comb begin
    unique case (prescale_select_field)
      QT_PS_DIV12: pre_lim = QT_DIV12;
      QT_PS_DIV4:  pre_lim = QT_DIV4;
      QT_PS_DIV48: pre_lim = QT_DIV48;
      QT_PS_EXT8:  pre_lim = QT_DIV12;
    endcase
    next_pre_cnt = (pre_cnt + 6'h01 >= pre_lim) ? QT_DIV_RST : pre_cnt + 6'h01;
    next_d12_cnt = (d12_cnt + 6'h01 >= QT_DIV12) ? QT_DIV_RST : d12_cnt + 6'h01;
    d12_tick     = (d12_cnt + 6'h01 >= QT_DIV12);
    ext8_tick    = pin_rise[QT_PIN_EXT] && (ext8 == QT_OSC8_LAST);
    rtc8_tick    = pin_rise[QT_PIN_RTC] && (rtc8 == QT_OSC8_LAST);
    next_ext8    = ext8 + {2'h0, pin_rise[QT_PIN_EXT]};
    next_rtc8    = rtc8 + {2'h0, pin_rise[QT_PIN_RTC]};
    pre_tick     = (prescale_select_field == QT_PS_EXT8) ? ext8_tick
                                                         : (pre_cnt + 6'h01 >= pre_lim);
  end
  assign osc8_tick = {ext8_tick, rtc8_tick};

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pre_cnt <= QT_DIV_RST;
      d12_cnt <= QT_DIV_RST;
      ext8    <= QT_OSC_RST;
      rtc8    <= QT_OSC_RST;
    end else begin
      pre_cnt <= next_pre_cnt;
      d12_cnt <= next_d12_cnt;
      ext8    <= next_ext8;
      rtc8    <= next_rtc8;
    end
  end

  a_div12_gap: assert property (d12_tick |=> !d12_tick [*8])
    else $error("system /12 tick repeated too soon");
  a_div4_tick: assert property ((pre_tick && prescale_select_field == QT_PS_DIV4) ##1
      (prescale_select_field == QT_PS_DIV4) [*4] |-> pre_tick)
    else $error("prescaler /4 tick missing");

  // ----------------------------------------------------------------
  // Timers 0 and 1
  // ----------------------------------------------------------------
  logic set01_lo [2];
  logic set01_hi [2];

  for (genvar i = 0; i < 2; i++) begin : g_t01
    logic        tmr_tick, cnt_tick, en, ld;
    logic [12:0] v13;
    logic [15:0] next_cnt;

    assign tmr_tick = t01_cfg[i].clk_sys | pre_tick;
    assign cnt_tick = t01_cfg[i].count_mode ? pin_fall[QT_PIN_CNT0 + i] : tmr_tick;
    assign en = t01_cfg[i].run_bit &&
                (!t01_cfg[i].gate_enable || pin_s2[QT_PIN_GATE + i]);
    assign ld = load.valid && (load.timer == 2'(i));

    // Next count per mode; split halts timer 1
    always_comb begin
      v13         = {t01_count[i][15:8], t01_count[i][4:0]};
      next_cnt    = t01_count[i];
      set01_lo[i] = 1'b0;
      set01_hi[i] = 1'b0;
      if (ld) begin
        next_cnt = load.data;
      end else begin
        unique case (t01_cfg[i].mode)
          QT_M_13BIT: if (en && cnt_tick) begin
            v13         = v13 + 13'h0001;
            next_cnt    = {v13[12:5], t01_count[i][7:5], v13[4:0]};
            set01_lo[i] = (v13 == 13'h0000);
          end
          QT_M_16BIT: if (en && cnt_tick) begin
            next_cnt    = t01_count[i] + 16'h0001;
            set01_lo[i] = (t01_count[i] == 16'hFFFF);
          end
          QT_M_RELOAD8: if (en && cnt_tick) begin
            set01_lo[i] = (t01_count[i][7:0] == 8'hFF);
            next_cnt[7:0] = set01_lo[i] ? t01_count[i][15:8] : t01_count[i][7:0] + 8'h01;
          end
          QT_M_SPLIT: if (i == 0) begin
            if (en && cnt_tick) begin
              next_cnt[7:0] = t01_count[i][7:0] + 8'h01;
              set01_lo[i]   = (t01_count[i][7:0] == 8'hFF);
            end
            if (t01_cfg[1].run_bit && tmr_tick) begin
              next_cnt[15:8] = t01_count[i][15:8] + 8'h01;
              set01_hi[i]    = (t01_count[i][15:8] == 8'hFF);
            end
          end
        endcase
      end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) t01_count[i] <= QT_CNT_RST;
      else             t01_count[i] <= next_cnt;
    end

    a_wrap_13bit: assert property ((t01_cfg[i].mode == QT_M_13BIT && en && cnt_tick && !ld &&
        v13 == 13'h0000) |=> (t01_count[i][15:8] == 8'h00 && t01_count[i][4:0] == 5'h00 &&
        overflow_flags[QT_F_TMR0 + i]))
      else $error("13-bit wrap did not clear count and set flag");
    a_reload_low: assert property ((t01_cfg[i].mode == QT_M_RELOAD8 && en && cnt_tick && !ld &&
        t01_count[i][7:0] == 8'hFF) |=> (t01_count[i][7:0] == $past(t01_count[i][15:8]) &&
        $stable(t01_count[i][15:8])))
      else $error("8-bit reload wrong");
    a_gate_hold: assert property ((t01_cfg[i].mode != QT_M_SPLIT && !ld &&
        (!t01_cfg[i].run_bit || (t01_cfg[i].gate_enable && !pin_s2[QT_PIN_GATE + i])))
        |=> $stable(t01_count[i]))
      else $error("timer counted while disabled");
    a_pin_edge: assert property ((t01_cfg[i].mode == QT_M_16BIT && t01_cfg[i].count_mode &&
        en && !ld) |=> (t01_count[i] == $past(t01_count[i]) +
        16'($past(pin_s3[QT_PIN_CNT0 + i] && !pin_s2[QT_PIN_CNT0 + i]))))
      else $error("counter did not follow one count per falling edge");
  end

  // ----------------------------------------------------------------
  // Timers 2 and 3
  // ----------------------------------------------------------------
  logic set23_lo [2];
  logic set23_hi [2];

  for (genvar j = 0; j < 2; j++) begin : g_t23
    logic        alt_tick, lo_tick, hi_tick, ld;
    logic [15:0] next_cnt, next_rl;

    assign alt_tick = t23_cfg[j].alt_cmp ? pin_rise[QT_PIN_CMP0 + j] : osc8_tick[j];
    assign lo_tick  = t23_cfg[j].low_sys ||
                      ((t23_cfg[j].alt_clk && !t23_cfg[j].capture) ? alt_tick : d12_tick);
    assign hi_tick  = t23_cfg[j].high_sys || (t23_cfg[j].alt_clk ? alt_tick : d12_tick);
    assign ld = load.valid && (load.timer == 2'(j + 2));

    // Split reload, 16-bit reload, or free run with capture
    always_comb begin
      next_cnt    = t23_count[j];
      next_rl     = t23_reload[j];
      set23_lo[j] = 1'b0;
      set23_hi[j] = 1'b0;
      if (t23_cfg[j].run_bit) begin
        if (t23_cfg[j].split) begin
          if (lo_tick) begin
            set23_lo[j]   = (t23_count[j][7:0] == 8'hFF);
            next_cnt[7:0] = set23_lo[j] ? t23_reload[j][7:0] : t23_count[j][7:0] + 8'h01;
          end
          if (hi_tick) begin
            set23_hi[j]    = (t23_count[j][15:8] == 8'hFF);
            next_cnt[15:8] = set23_hi[j] ? t23_reload[j][15:8] : t23_count[j][15:8] + 8'h01;
          end
        end else if (lo_tick) begin
          set23_hi[j] = (t23_count[j] == 16'hFFFF);
          next_cnt    = (set23_hi[j] && !t23_cfg[j].capture) ? t23_reload[j]
                                                             : t23_count[j] + 16'h0001;
        end
        if (t23_cfg[j].capture && !t23_cfg[j].split && alt_tick) begin
          next_rl     = t23_count[j];
          set23_lo[j] = 1'b1;
        end
      end
      if (ld && !load.reload) next_cnt = load.data;
      if (ld && load.reload)  next_rl  = load.data;
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        t23_count[j]  <= QT_CNT_RST;
        t23_reload[j] <= QT_CNT_RST;
      end else begin
        t23_count[j]  <= next_cnt;
        t23_reload[j] <= next_rl;
      end
    end

    a_reload_16bit: assert property ((t23_cfg[j].run_bit && !t23_cfg[j].split &&
        !t23_cfg[j].capture && lo_tick && !ld && t23_count[j] == 16'hFFFF) |=>
        (t23_count[j] == $past(t23_reload[j]) && overflow_flags[QT_F_T2H + 2 * j]))
      else $error("16-bit reload or flag missing");
    a_capture_take: assert property ((t23_cfg[j].run_bit && t23_cfg[j].capture &&
        !t23_cfg[j].split && alt_tick && !ld) |=>
        (t23_reload[j] == $past(t23_count[j]) && overflow_flags[QT_F_T2L + 2 * j]))
      else $error("capture did not latch count");
  end

  // ----------------------------------------------------------------
  // Overflow flags: hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  logic [5:0] flag_set, next_flags;

  always_comb begin
    flag_set            = QT_FLAG_RST;
    flag_set[QT_F_TMR0] = set01_lo[0];
    flag_set[QT_F_TMR1] = set01_lo[1] | set01_hi[0];
    for (int k = 0; k < 2; k++) begin
      flag_set[QT_F_T2L + 2 * k] = set23_lo[k];
      flag_set[QT_F_T2H + 2 * k] = set23_hi[k];
    end
    next_flags = (overflow_flags & ~flag_clear) | flag_set;
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) overflow_flags <= QT_FLAG_RST;
    else             overflow_flags <= next_flags;
  end

  a_flag_set_wins: assert property ((|flag_set) |=>
      ((overflow_flags & $past(flag_set)) == $past(flag_set)))
    else $error("overflow event lost");

endmodule : qt_timers

`default_nettype wire

// ### qt_pin_src.sv
// Far-side model of the count pins and the free external oscillator.
// Assumes the bench calls pulse() from its own thread at a falling edge.
`default_nettype none

module qt_pin_src (
  input  wire logic clk,
  output var logic  count_input_pin_0,
  output var logic  count_input_pin_1,
  output var logic  ext_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle high; oscillator toggles every two clocks
  initial begin
    count_input_pin_0 = 1'b1;
    count_input_pin_1 = 1'b1;
    ext_osc_clk       = 1'b0;
    forever begin
      repeat (2) @(negedge clk);
      ext_osc_clk = ~ext_osc_clk;
    end
  end

  // One event: low two clocks, high two clocks, so the rate is clk/4
  task automatic pulse(input int idx);
    if (idx == 0) count_input_pin_0 = 1'b0;
    else count_input_pin_1 = 1'b0;
    repeat (2) @(negedge clk);
    count_input_pin_0 = 1'b1;
    count_input_pin_1 = 1'b1;
    repeat (2) @(negedge clk);
  endtask : pulse
endmodule : qt_pin_src

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the four counter/timers.
// Assumes qt_pkg and qt_timers compiled first; inputs change at falling edges.
`default_nettype none

module tb_top
  import qt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int sel; logic [15:0] val;} qt_note_t;

  logic         clk = 1'b0;
  logic         rst_b, gate_pin0, gate_pin1, rtc, cmp0, cmp1;
  wire logic    pin0, pin1, osc;
  qt_prescale_t ps;
  qt_t01_cfg_t  c01 [2];
  qt_t23_cfg_t  c23 [2];
  qt_load_t     load;
  logic [5:0]   fclr, flags;
  logic [15:0]  c01o [2], c23o [2], rl23 [2];
  int           err_count, num_checks, cycles, n_ev;
  qt_note_t     q[$];
  qt_note_t     n;
  event         look;
  string        nm [6] = '{"timer0_count", "timer1_count", "timer2_count", "timer3_count",
                           "flags", "timer2_capture"};
  int           div [4] = '{QT_DIV12, QT_DIV4, QT_DIV48, 32};

  qt_pin_src u_src (.clk(clk), .count_input_pin_0(pin0), .count_input_pin_1(pin1),
                    .ext_osc_clk(osc));

  qt_timers u_dut (
    .clk(clk), .rst_b(rst_b), .count_input_pin_0(pin0), .count_input_pin_1(pin1),
    .timer0_gate_input(gate_pin0), .timer1_gate_input(gate_pin1), .ext_osc_clk(osc),
    .rtc_osc_clk(rtc), .comparator0_out(cmp0), .comparator1_out(cmp1),
    .prescale_select_field(ps), .t01_cfg(c01), .t23_cfg(c23), .load(load),
    .flag_clear(fclr), .t01_count(c01o), .t23_count(c23o), .t23_reload(rl23),
    .overflow_flags(flags)
  );

  // Clock at 125 MHz
  always #4 clk = ~clk;

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      end_of_test();
    end
  end

  function automatic logic [15:0] obs(input int s);
    if (s < 2) return c01o[s];
    if (s < 4) return c23o[s-2];
    if (s == 5) return rl23[0];
    return {10'h000, flags};
  endfunction : obs

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Watcher takes the oldest notes and compares them with the outputs
  always @(look) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      check(nm[n.sel], obs(n.sel), n.val);
    end
  end

  task automatic chk(input int s, input logic [15:0] v);
    q.push_back('{s, v});
    -> look;
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic ld(input int t, input logic rl, input logic [15:0] d);
    load = '{1'b1, 2'(t), rl, d};
    cyc(1);
    load.valid = 1'b0;
    cyc(1);
  endtask : ld

  task automatic clr();
    fclr = 6'h3F;
    cyc(1);
    fclr = 6'h00;
    cyc(1);
  endtask : clr

  task automatic alt_src(input int k, input logic v);
    if (k == 0) cmp0 = v;
    else if (k == 1) cmp1 = v;
    else if (k == 2) rtc = v;
  endtask : alt_src

  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    void'($urandom(62038));
    {rst_b, gate_pin0, gate_pin1, rtc, cmp0, cmp1} = 6'h00;
    ps = QT_PS_DIV12;
    c01 = '{default: '0};
    c23 = '{default: '0};
    load = '0;
    fclr = 6'h00;
    cyc(3);
    rst_b = 1'b1;
    cyc(3);
    chk(0, 16'h0000);
    chk(4, 16'h0000);
    ld(0, 0, 16'hFFFE);
    c01[0] = '{1'b1, 1'b0, 1'b0, 1'b1, QT_M_16BIT};
    cyc(2);
    c01[0].run_bit = 1'b0;
    chk(0, 16'h0000);
    chk(4, 16'h0001);
    clr();
    ld(1, 0, 16'hFF1E);
    c01[1] = '{1'b1, 1'b0, 1'b0, 1'b1, QT_M_13BIT};
    cyc(2);
    c01[1].run_bit = 1'b0;
    chk(1, 16'h0000);
    chk(4, 16'h0002);
    clr();
    ld(0, 0, 16'h80FE);
    c01[0] = '{1'b1, 1'b0, 1'b0, 1'b1, QT_M_RELOAD8};
    cyc(2);
    c01[0].run_bit = 1'b0;
    chk(0, 16'h8080);
    chk(4, 16'h0001);
    clr();
    // Split timer 0 while timer 1 holds
    ld(0, 0, 16'h01FF);
    ld(1, 0, 16'h5555);
    c01[0] = '{1'b1, 1'b0, 1'b0, 1'b1, QT_M_SPLIT};
    c01[1] = '{1'b1, 1'b0, 1'b0, 1'b1, QT_M_SPLIT};
    cyc(2);
    c01[0].run_bit = 1'b0;
    c01[1].run_bit = 1'b0;
    chk(0, 16'h0301);
    chk(1, 16'h5555);
    chk(4, 16'h0001);
    clr();
    // Gate low blocks counting, gate high lets it through
    ld(0, 0, 16'h0000);
    ld(1, 0, 16'h0000);
    for (int g = 0; g < 2; g++) begin
      {gate_pin1, gate_pin0} = {2{g[0]}};
      cyc(6);
      c01[1] = '{1'b1, 1'b1, 1'b0, 1'b1, QT_M_16BIT};
      c01[0] = c01[1];
      cyc(4);
      c01[0].run_bit = 1'b0;
      c01[1].run_bit = 1'b0;
      chk(0, 16'(4 * g));
      chk(1, 16'(4 * g));
    end
    // Each prescale choice gives three ticks in three periods
    for (int p = 0; p < 4; p++) begin
      ps = qt_prescale_t'(p);
      cyc(100);
      ld(0, 0, 16'h0000);
      c01[0] = '{1'b1, 1'b0, 1'b0, 1'b0, QT_M_16BIT};
      cyc(3 * div[p]);
      c01[0].run_bit = 1'b0;
      chk(0, 16'h0003);
    end
    // Random number of pin events per counter
    for (int i = 0; i < 2; i++) begin
      n_ev = 1 + $urandom % 6;
      ld(i, 0, 16'h0000);
      c01[i] = '{1'b1, 1'b0, 1'b1, 1'b0, QT_M_16BIT};
      repeat (n_ev) u_src.pulse(i);
      cyc(6);
      c01[i].run_bit = 1'b0;
      chk(i, 16'(n_ev));
    end
    ld(2, 1, 16'h1234);
    ld(2, 0, 16'hFFFE);
    c23[0] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    cyc(2);
    c23[0].run_bit = 1'b0;
    chk(2, 16'h1234);
    chk(4, 16'h0008);
    clr();
    ld(3, 1, 16'hA0B0);
    ld(3, 0, 16'hFEFF);
    c23[1] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    cyc(1);
    chk(3, 16'hFFB0);
    chk(4, 16'h0010);
    cyc(1);
    c23[1].run_bit = 1'b0;
    chk(3, 16'hA0B1);
    chk(4, 16'h0030);
    clr();
    ld(2, 0, 16'h0000);
    c23[0] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    cyc(36);
    c23[0].run_bit = 1'b0;
    chk(2, 16'h0003);
    // Alternate clocks: comparators, rtc /8, external oscillator /8
    for (int k = 0; k < 4; k++) begin
      ld(2 + k % 2, 0, 16'h0000);
      c23[k % 2] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, k < 2};
      if (k == 3) cyc(92);
      repeat (k < 2 ? 4 : (k == 2 ? 16 : 0)) begin
        alt_src(k, 1'b1);
        cyc(3);
        alt_src(k, 1'b0);
        cyc(3);
      end
      cyc(4);
      c23[k % 2].run_bit = 1'b0;
      chk(2 + k % 2, k < 2 ? 16'h0004 : (k == 2 ? 16'h0002 : 16'h0003));
    end
    // Capture on a comparator edge sets the low flag
    clr();
    c23[0] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    cmp0 = 1'b1;
    cyc(6);
    c23[0].run_bit = 1'b0;
    cmp0 = 1'b0;
    chk(4, 16'h0004);
    chk(5, 16'h0004);
    cyc(2);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
